//--- hdl/ic_ctrl.sv
// Operation
// - Global enable is bit 0 of control A; zero blocks every interrupt.
// - Control A holds converter, pin1, pin0 flags at 6..4, enables at 3..1.
// - Control B holds tb0, serial, group1, group0 flags 7..4, enables 3..0.
// - Control C holds tb1 flag at 4, enable at 0; rest reads zero.
// - Timer group register holds four match flags 7..4, enables 3..0.
// - Eeprom group register holds eeprom/low-volt flags 5,4, enables 1,0.
// - Unused bits of all five registers read zero, ignore writes.
// - A source event sets its flag regardless of enables.
// - A set flag vectors only when its enable is one.
// - Taking an interrupt pushes the next PC and loads the vector.
// - Return from interrupt pops the saved PC.
// - Servicing clears the global enable, blocking nesting.
// - Events while globally disabled still set flags and stay pending.
// - No request is taken while the stack is full.
// - Simultaneous enabled requests resolve by a fixed priority.
// - Timer, eeprom and low-volt sources share group vectors.
// - Any flag rising wakes the core; pre-set flags do not.
// - Servicing a pin interrupt clears that pin flag too.
// - Group requests come from enabled member sources or from control B flag writes.
`include "ic_regs.svh"

module ic_ctrl #(
  parameter int PC_W  = 12,
  parameter int DEPTH = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [2:0]         av_address_i,
  input  wire logic               av_read_i,
  input  wire logic               av_write_i,
  input  wire logic [31:0]        av_writedata_i,
  input  wire logic [3:0]         av_byteenable_i,
  output logic [31:0]             av_readdata_o,
  output logic                    av_waitrequest_o,
  input  wire ic_pkg::ic_evt_type evt_i,
  input  wire logic               cpu_ready_i,
  input  wire logic [PC_W-1:0]    pc_next_i,
  input  wire logic               return_from_interrupt_i,
  output logic                    irq_take_o,
  output logic [PC_W-1:0]         irq_vector_o,
  output logic                    ret_valid_o,
  output logic [PC_W-1:0]         ret_pc_o,
  output logic                    wake_o
);

  // ****************************************
  // State
  // ****************************************
  logic                gie_reg;
  logic                gie_next;
  logic [7:0]          prim_flag_reg;
  logic [7:0]          prim_flag_next;
  logic [7:0]          prim_en_reg;
  logic [7:0]          prim_en_next;
  logic [5:0]          mem_flag_reg;
  logic [5:0]          mem_flag_next;
  logic [5:0]          mem_en_reg;
  logic [5:0]          mem_en_next;
  logic [1:0]          grp_hit_reg;
  logic [1:0]          grp_hit;
  logic                wait_reg;
  logic [31:0]         rdata_reg;
  logic                take_reg;
  logic [2:0]          take_idx_reg;
  logic [PC_W-1:0]     vec_reg;
  logic                retv_reg;
  logic [PC_W-1:0]     ret_pc_reg;
  logic                wake_reg;
  ic_pkg::ic_state_type st_reg;
  ic_pkg::ic_state_type st_next;

  logic [7:0]          prim_set;
  logic [5:0]          mem_set;
  logic [7:0]          prim_req;
  logic                pick_valid;
  logic [2:0]          pick_idx;
  logic                stk_full;
  logic                stk_empty;
  logic [PC_W-1:0]     stk_top;
  logic                take_go;
  logic                ret_go;
  logic                acc;
  logic                wr_lo;
  logic [7:0]          wb;

  // ****************************************
  // Helpers
  // ****************************************

  // Vector address of a primary source
  function automatic logic [PC_W-1:0] ic_vec(input logic [2:0] idx);
    logic [11:0] v;
    v = `IC_VEC_BASE + `IC_VEC_STEP * {9'h000, idx};
    return PC_W'(v);
  endfunction : ic_vec

  // Pack the live state into a register byte
  function automatic logic [7:0] ic_rd(input logic [2:0] a,
                                       input logic       g,
                                       input logic [7:0] f,
                                       input logic [7:0] e,
                                       input logic [5:0] m,
                                       input logic [5:0] me);
    logic [7:0] b;
    b = `IC_RST_BYTE;
    case (a)
      `IC_REG_CTRL_A: begin
        b[`IC_A_GIE]       = g;
        b[`IC_A_PIN0_EN]   = e[`IC_SRC_PIN0];
        b[`IC_A_PIN1_EN]   = e[`IC_SRC_PIN1];
        b[`IC_A_CONV_EN]   = e[`IC_SRC_CONV];
        b[`IC_A_PIN0_FLAG] = f[`IC_SRC_PIN0];
        b[`IC_A_PIN1_FLAG] = f[`IC_SRC_PIN1];
        b[`IC_A_CONV_FLAG] = f[`IC_SRC_CONV];
      end
      `IC_REG_CTRL_B: begin
        b[`IC_B_GRP0_EN]   = e[`IC_SRC_GRP0];
        b[`IC_B_GRP1_EN]   = e[`IC_SRC_GRP1];
        b[`IC_B_SER_EN]    = e[`IC_SRC_SER];
        b[`IC_B_TB0_EN]    = e[`IC_SRC_TB0];
        b[`IC_B_GRP0_FLAG] = f[`IC_SRC_GRP0];
        b[`IC_B_GRP1_FLAG] = f[`IC_SRC_GRP1];
        b[`IC_B_SER_FLAG]  = f[`IC_SRC_SER];
        b[`IC_B_TB0_FLAG]  = f[`IC_SRC_TB0];
      end
      `IC_REG_CTRL_C: begin
        b[`IC_C_TB1_EN]    = e[`IC_SRC_TB1];
        b[`IC_C_TB1_FLAG]  = f[`IC_SRC_TB1];
      end
      `IC_REG_GRP_TMR: begin
        for (int i = 0; i < 4; i++) begin
          b[`IC_G_FLAG_LSB + 3 - i] = m[i];
          b[`IC_G_EN_LSB + 3 - i]   = me[i];
        end
      end
      `IC_REG_GRP_EEP: begin
        b[`IC_G_FLAG_LSB + 1] = m[`IC_MEM_EEP];
        b[`IC_G_FLAG_LSB]     = m[`IC_MEM_LV];
        b[`IC_G_EN_LSB + 1]   = me[`IC_MEM_EEP];
        b[`IC_G_EN_LSB]       = me[`IC_MEM_LV];
      end
      default: b = `IC_RST_BYTE;
    endcase
    return b;
  endfunction : ic_rd

  // ****************************************
  // Bus slave
  // ****************************************

  // One wait cycle per access, then accept
  always_comb begin
    acc   = (av_read_i | av_write_i) & ~wait_reg;
    wr_lo = acc & av_write_i & av_byteenable_i[0];
    wb    = av_writedata_i[7:0];
  end

  // Waitrequest drops for exactly the accepting cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((av_read_i | av_write_i) & wait_reg);
    end
  end

  // Read data sampled in the wait cycle; upper bytes stay zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (av_read_i & wait_reg) begin
      rdata_reg <= {24'h000000, ic_rd(av_address_i, gie_reg,
                     prim_flag_reg, prim_en_reg,
                     mem_flag_reg, mem_en_reg)};
    end
  end

  // ****************************************
  // Event capture and group derivation
  // ****************************************

  // Group hit needs an enabled member; edge-detected so a
  // still-set member does not re-raise a just-serviced group
  always_comb begin
    grp_hit[0] = |(mem_flag_reg[3:0] & mem_en_reg[3:0]);
    grp_hit[1] = |(mem_flag_reg[5:4] & mem_en_reg[5:4]);
    mem_set = {evt_i.low_volt, evt_i.eeprom, evt_i.ctm_p,
               evt_i.ctm_a, evt_i.ptm_p, evt_i.ptm_a};
    prim_set = {evt_i.tb1, evt_i.tb0,
                grp_hit[1] & ~grp_hit_reg[1],
                grp_hit[0] & ~grp_hit_reg[0],
                evt_i.serial, evt_i.conv,
                evt_i.pin1, evt_i.pin0};
  end

  // Previous group hit level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      grp_hit_reg <= 2'b00;
    end else begin
      grp_hit_reg <= grp_hit;
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************

  // Requests that may vector
  always_comb begin
    prim_req = prim_flag_reg & prim_en_reg;
  end

  ic_prio u_prio (
    .req_i   (prim_req),
    .valid_o (pick_valid),
    .idx_o   (pick_idx)
  );

  ic_stack #(
    .DEPTH (DEPTH),
    .PC_W  (PC_W)
  ) u_stack (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .push_i  (take_go),
    .pop_i   (ret_go),
    .din_i   (pc_next_i),
    .top_o   (stk_top),
    .full_o  (stk_full),
    .empty_o (stk_empty)
  );

  // Take only at an instruction boundary; return has priority
  always_comb begin
    ret_go  = (st_reg == ic_pkg::IC_IDLE) & return_from_interrupt_i & ~stk_empty;
    take_go = (st_reg == ic_pkg::IC_IDLE) & cpu_ready_i & ~return_from_interrupt_i
            & gie_reg
            & pick_valid
            & ~stk_full;
  end

  // Sequencer
  always_comb begin
    case (st_reg)
      ic_pkg::IC_IDLE: begin
        if (ret_go) begin
          st_next = ic_pkg::IC_RET;
        end else if (take_go) begin
          st_next = ic_pkg::IC_SVC;
        end else begin
          st_next = ic_pkg::IC_IDLE;
        end
      end
      ic_pkg::IC_SVC: st_next = ic_pkg::IC_IDLE;
      ic_pkg::IC_RET: st_next = ic_pkg::IC_IDLE;
      default:        st_next = ic_pkg::IC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ic_pkg::IC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Register next values
  // ****************************************

  // Order: service clear, then software write, then events;
  // an event in the clearing cycle therefore survives
  always_comb begin
    gie_next       = gie_reg;
    prim_flag_next = prim_flag_reg;
    prim_en_next   = prim_en_reg;
    mem_flag_next  = mem_flag_reg;
    mem_en_next    = mem_en_reg;
    if (take_go) begin
      prim_flag_next[pick_idx] = 1'b0;
    end
    if (wr_lo) begin
      case (av_address_i)
        `IC_REG_CTRL_A: begin
          gie_next = wb[`IC_A_GIE];
          prim_en_next[`IC_SRC_PIN0]   = wb[`IC_A_PIN0_EN];
          prim_en_next[`IC_SRC_PIN1]   = wb[`IC_A_PIN1_EN];
          prim_en_next[`IC_SRC_CONV]   = wb[`IC_A_CONV_EN];
          prim_flag_next[`IC_SRC_PIN0] = wb[`IC_A_PIN0_FLAG];
          prim_flag_next[`IC_SRC_PIN1] = wb[`IC_A_PIN1_FLAG];
          prim_flag_next[`IC_SRC_CONV] = wb[`IC_A_CONV_FLAG];
        end
        `IC_REG_CTRL_B: begin
          prim_en_next[`IC_SRC_GRP0]   = wb[`IC_B_GRP0_EN];
          prim_en_next[`IC_SRC_GRP1]   = wb[`IC_B_GRP1_EN];
          prim_en_next[`IC_SRC_SER]    = wb[`IC_B_SER_EN];
          prim_en_next[`IC_SRC_TB0]    = wb[`IC_B_TB0_EN];
          prim_flag_next[`IC_SRC_GRP0] = wb[`IC_B_GRP0_FLAG];
          prim_flag_next[`IC_SRC_GRP1] = wb[`IC_B_GRP1_FLAG];
          prim_flag_next[`IC_SRC_SER]  = wb[`IC_B_SER_FLAG];
          prim_flag_next[`IC_SRC_TB0]  = wb[`IC_B_TB0_FLAG];
        end
        `IC_REG_CTRL_C: begin
          prim_en_next[`IC_SRC_TB1]   = wb[`IC_C_TB1_EN];
          prim_flag_next[`IC_SRC_TB1] = wb[`IC_C_TB1_FLAG];
        end
        `IC_REG_GRP_TMR: begin
          for (int i = 0; i < 4; i++) begin
            mem_flag_next[i] = wb[`IC_G_FLAG_LSB + 3 - i];
            mem_en_next[i]   = wb[`IC_G_EN_LSB + 3 - i];
          end
        end
        `IC_REG_GRP_EEP: begin
          mem_flag_next[`IC_MEM_EEP] = wb[`IC_G_FLAG_LSB + 1];
          mem_flag_next[`IC_MEM_LV]  = wb[`IC_G_FLAG_LSB];
          mem_en_next[`IC_MEM_EEP]   = wb[`IC_G_EN_LSB + 1];
          mem_en_next[`IC_MEM_LV]    = wb[`IC_G_EN_LSB];
        end
        default: gie_next = gie_reg;
      endcase
    end
    prim_flag_next = prim_flag_next | prim_set;
    mem_flag_next  = mem_flag_next | mem_set;
    if (ret_go) begin
      gie_next = 1'b1;
    end
    if (take_go) begin
      gie_next = 1'b0;
    end
  end

  // Flags and enables
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gie_reg       <= 1'b0;
      prim_flag_reg <= `IC_RST_BYTE;
      prim_en_reg   <= `IC_RST_BYTE;
      mem_flag_reg  <= 6'h00;
      mem_en_reg    <= 6'h00;
    end else begin
      gie_reg       <= gie_next;
      prim_flag_reg <= prim_flag_next;
      prim_en_reg   <= prim_en_next;
      mem_flag_reg  <= mem_flag_next;
      mem_en_reg    <= mem_en_next;
    end
  end

  // ****************************************
  // Core-facing outputs
  // ****************************************

  // Vector strobe; group sources share a group vector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      take_reg     <= 1'b0;
      take_idx_reg <= 3'h0;
      vec_reg      <= '0;
    end else begin
      take_reg <= take_go;
      if (take_go) begin
        take_idx_reg <= pick_idx;
        vec_reg      <= ic_vec(pick_idx);
      end
    end
  end

  // Return address strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      retv_reg   <= 1'b0;
      ret_pc_reg <= '0;
    end else begin
      retv_reg <= ret_go;
      if (ret_go) begin
        ret_pc_reg <= stk_top;
      end
    end
  end

  // Wake only on a 0-to-1 flag change, so pre-set flags stay quiet
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |(prim_flag_next & ~prim_flag_reg)
                | |(mem_flag_next & ~mem_flag_reg);
    end
  end

  assign av_waitrequest_o = wait_reg;
  assign av_readdata_o    = rdata_reg;
  assign irq_take_o       = take_reg;
  assign irq_vector_o     = vec_reg;
  assign ret_valid_o      = retv_reg;
  assign ret_pc_o         = ret_pc_reg;
  assign wake_o           = wake_reg;

  // ****************************************
  // Checks
  // ****************************************

  property p_gie_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> $past(gie_reg);
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("interrupt taken with global enable low");

  property p_gie_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> !gie_reg;
  endproperty
  a_gie_clr: assert property (p_gie_clr)
    else $error("global enable not cleared on service");

  property p_en_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> $past(prim_en_reg[pick_idx] & prim_flag_reg[pick_idx]);
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("interrupt taken from a disabled source");

  property p_full;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> $past(!stk_full);
  endproperty
  a_full: assert property (p_full)
    else $error("interrupt taken with stack full");

  property p_prio;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> ($past(prim_req) & ((8'h01 << take_idx_reg) - 8'h01)) == 8'h00;
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower priority source won");

  property p_vec;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_take_o |-> irq_vector_o == ic_vec(take_idx_reg);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector does not match taken source");

  property p_pend;
    @(posedge clk_i) disable iff (!rst_n_i)
    !gie_reg && evt_i.conv |=> prim_flag_reg[`IC_SRC_CONV];
  endproperty
  a_pend: assert property (p_pend)
    else $error("request lost while disabled");

  property p_pin_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    take_go && pick_idx == `IC_SRC_PIN0 && !evt_i.pin0 && !wr_lo
      |=> !prim_flag_reg[`IC_SRC_PIN0];
  endproperty
  a_pin_clr: assert property (p_pin_clr)
    else $error("pin flag not cleared on service");

  property p_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
    !prim_flag_reg[`IC_SRC_TB0] && evt_i.tb0 |=> wake_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("flag rise did not wake");

  property p_rd_hi;
    @(posedge clk_i) disable iff (!rst_n_i)
    av_read_i && !av_waitrequest_o |-> av_readdata_o[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("upper read bits not zero");

endmodule : ic_ctrl

//--- hdl/ic_regs.svh
`ifndef IC_REGS_SVH
`define IC_REGS_SVH

// ****************************************
// Register word indices on the bus
// ****************************************
`define IC_REG_CTRL_A    3'h0
`define IC_REG_CTRL_B    3'h1
`define IC_REG_CTRL_C    3'h2
`define IC_REG_GRP_TMR   3'h3
`define IC_REG_GRP_EEP   3'h4

// ****************************************
// Field positions
// ****************************************
`define IC_A_GIE         0
`define IC_A_PIN0_EN     1
`define IC_A_PIN1_EN     2
`define IC_A_CONV_EN     3
`define IC_A_PIN0_FLAG   4
`define IC_A_PIN1_FLAG   5
`define IC_A_CONV_FLAG   6
`define IC_B_GRP0_EN     0
`define IC_B_GRP1_EN     1
`define IC_B_SER_EN      2
`define IC_B_TB0_EN      3
`define IC_B_GRP0_FLAG   4
`define IC_B_GRP1_FLAG   5
`define IC_B_SER_FLAG    6
`define IC_B_TB0_FLAG    7
`define IC_C_TB1_EN      0
`define IC_C_TB1_FLAG    4
`define IC_G_EN_LSB      0
`define IC_G_FLAG_LSB    4

// ****************************************
// Source indices, also the priority order
// ****************************************
`define IC_SRC_PIN0      3'h0
`define IC_SRC_PIN1      3'h1
`define IC_SRC_CONV      3'h2
`define IC_SRC_SER       3'h3
`define IC_SRC_GRP0      3'h4
`define IC_SRC_GRP1      3'h5
`define IC_SRC_TB0       3'h6
`define IC_SRC_TB1       3'h7

// Member indices: timer group 0..3, eeprom group 4..5
`define IC_MEM_PTM_A     0
`define IC_MEM_PTM_P     1
`define IC_MEM_CTM_A     2
`define IC_MEM_CTM_P     3
`define IC_MEM_EEP       4
`define IC_MEM_LV        5

// ****************************************
// Vector map and reset values
// ****************************************
`define IC_VEC_BASE      12'h004
`define IC_VEC_STEP      12'h004
`define IC_RST_BYTE      8'h00

`endif

//--- hdl/ic_pkg.sv
package ic_pkg;

  // ****************************************
  // Event strobes from the peripherals
  // ****************************************
  typedef struct packed {
    logic pin0;
    logic pin1;
    logic conv;
    logic serial;
    logic tb0;
    logic tb1;
    logic ptm_a;
    logic ptm_p;
    logic ctm_a;
    logic ctm_p;
    logic eeprom;
    logic low_volt;
  } ic_evt_type;

  // Sequencer states, Gray along idle-service-idle
  typedef enum logic [1:0] {
    IC_IDLE = 2'b00,
    IC_SVC  = 2'b01,
    IC_RET  = 2'b10
  } ic_state_type;

endpackage : ic_pkg

//--- hdl/ic_prio.sv
// Fixed priority pick: lowest index wins
module ic_prio (
  input  wire logic [7:0] req_i,
  output logic            valid_o,
  output logic [2:0]      idx_o
);

  // Scan from the top so the lowest index is last to win
  function automatic logic [2:0] ic_first(input logic [7:0] r);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (r[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction : ic_first

  // Pick
  always_comb begin
    valid_o = |req_i;
    idx_o   = ic_first(req_i);
  end

endmodule : ic_prio

//--- hdl/ic_stack.sv
// Return-address stack for serviced interrupts
module ic_stack #(
  parameter int DEPTH = 8,
  parameter int PC_W  = 12
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            push_i,
  input  wire logic            pop_i,
  input  wire logic [PC_W-1:0] din_i,
  output logic [PC_W-1:0]      top_o,
  output logic                 full_o,
  output logic                 empty_o
);

  logic [PC_W-1:0]          mem_reg [DEPTH];
  logic [$clog2(DEPTH):0]   sp_reg;
  logic [$clog2(DEPTH):0]   sp_dec;

  // Pointer; callers never push when full or pop when empty
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sp_reg <= '0;
    end else if (push_i) begin
      sp_reg <= sp_reg + 1'b1;
    end else if (pop_i) begin
      sp_reg <= sp_reg - 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem_reg[sp_reg[$clog2(DEPTH)-1:0]] <= din_i;
    end
  end

  // Status and top word
  always_comb begin
    full_o  = (sp_reg == ($clog2(DEPTH)+1)'(DEPTH));
    empty_o = (sp_reg == '0);
    sp_dec  = sp_reg - 1'b1;
    top_o   = empty_o ? '0 : mem_reg[sp_dec[$clog2(DEPTH)-1:0]];
  end

endmodule : ic_stack

//--- tb/ic_core_model.sv
// Behavioural core: ready at boundaries, pushes and resumes PCs
module ic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ready_en_i,
  input  wire logic        slow_i,
  input  wire logic        ret_req_i,
  input  wire logic        take_i,
  input  wire logic [11:0] vec_i,
  input  wire logic        ret_i,
  input  wire logic [11:0] ret_pc_i,
  output logic             cpu_ready_o,
  output logic [11:0]      pc_next_o,
  output logic             return_from_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] saved[$];
  logic        rnd_reg;

  // PC only moves on take or return, so the pushed value is known
  always @(posedge clk_i) begin
    rnd_reg <= 1'($urandom);
    return_from_interrupt_o  <= ret_req_i & rst_n_i;
    if (!rst_n_i) begin
      pc_next_o <= 12'h100;
    end else if (take_i) begin
      saved.push_back(pc_next_o);
      pc_next_o <= vec_i + 12'h001;
    end else if (ret_i) begin
      pc_next_o <= ret_pc_i;
    end
  end

  // Slow mode drops ready at random boundaries; not ready while a
  // return is in flight, so a push sees the resumed PC
  assign cpu_ready_o = ready_en_i & (rnd_reg | !slow_i) & !return_from_interrupt_o & !ret_i;
endmodule : ic_core_model

//--- tb/mcu_interrupt_controller_test.sv
module mcu_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Signals
  // ******
  logic               clk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic [2:0]         av_address_i = 3'h0;
  logic               av_read_i = 1'b0;
  logic               av_write_i = 1'b0;
  logic [31:0]        av_writedata_i = 32'h0;
  logic [31:0]        av_readdata_o;
  logic               av_waitrequest_o, irq_take_o, ret_valid_o, wake_o, cpu_ready, return_from_interrupt;
  logic [11:0]        irq_vector_o, ret_pc_o, pc_next;
  ic_pkg::ic_evt_type evt_i = '0;
  logic               ready_en = 1'b0;
  logic               slow = 1'b0;
  logic               ret_req = 1'b0;
  logic [3:0]         be = 4'h1;
  int                 failures = 0;
  int                 checks = 0;
  int                 er[8] = '{0, 0, 0, 1, 1, 1, 1, 2};
  int                 eb[8] = '{1, 2, 3, 2, 0, 1, 3, 0};
  int                 ek[8] = '{11, 10, 9, 8, 5, 1, 7, 6};
  logic [7:0]         mask[6] = '{8'h7F, 8'hFF, 8'h11, 8'hFF, 8'h33, 8'h00};

  always #5 clk_i = ~clk_i;

  // Only byte 0 carries a register; byte enable is dropped once
  ic_ctrl dut (.clk_i, .rst_n_i, .av_address_i, .av_read_i, .av_write_i, .av_writedata_i,
    .av_byteenable_i(be), .av_readdata_o, .av_waitrequest_o, .evt_i, .cpu_ready_i(cpu_ready),
    .pc_next_i(pc_next), .return_from_interrupt_i(return_from_interrupt), .irq_take_o, .irq_vector_o, .ret_valid_o, .ret_pc_o,
    .wake_o);
  ic_core_model core (.clk_i, .rst_n_i, .ready_en_i(ready_en), .slow_i(slow),
    .ret_req_i(ret_req), .take_i(irq_take_o), .vec_i(irq_vector_o), .ret_i(ret_valid_o),
    .ret_pc_i(ret_pc_o), .cpu_ready_o(cpu_ready), .pc_next_o(pc_next), .return_from_interrupt_o(return_from_interrupt));

  // ******
  // Helpers
  // ******
  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    av_address_i <= a;
    av_writedata_i <= {24'h0, d};
    av_write_i <= w;
    av_read_i <= !w;
    do begin
      @(posedge clk_i);
    end while (av_waitrequest_o !== 1'b0);
    q = av_readdata_o[7:0];
    av_write_i <= 1'b0;
    av_read_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {4'h0, q}, {4'h0, e});
  endtask : rd

  // One-cycle strobe, then wake seen in the following cycle
  task automatic fire(input logic [11:0] e, input logic ew);
    @(posedge clk_i);
    evt_i <= ic_pkg::ic_evt_type'(e);
    @(posedge clk_i);
    evt_i <= '0;
    @(posedge clk_i);
    chk("wake", 12'(wake_o), 12'(ew));
  endtask : fire

  task automatic take(input logic ex, input logic [11:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq_take_o !== 1'b1 && n < 30);
    chk("take", 12'(irq_take_o), 12'(ex));
    if (ex) chk("vector", irq_vector_o, v);
  endtask : take

  task automatic ret();
    int n;
    n = 0;
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    while (ret_valid_o !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    chk("ret_valid", 12'(ret_valid_o), 12'h001);
    chk("ret_pc", ret_pc_o, core.saved.pop_back());
  endtask : ret

  function automatic int win(input logic [7:0] p);
    win = 8;
    for (int i = 7; i >= 0; i--) if (p[i]) win = i;
  endfunction : win

  function automatic logic [11:0] evv(input logic [7:0] f);
    evv = 12'h000;
    for (int i = 0; i < 8; i++) if (f[i]) evv |= 12'h001 << ek[i];
  endfunction : evv

  function automatic logic [7:0] enb(input logic [7:0] en, input int r);
    enb = 8'h00;
    for (int i = 0; i < 8; i++) if (en[i] && er[i] == r) enb |= 8'h01 << eb[i];
  endfunction : enb

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    conclude();
  end

  // ******
  // Main sequence
  // ******
  initial begin
    logic [7:0] en, fl, q;
    int         w;
    void'($urandom(32'h2bf9e7b4));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      rd(3'(r), 8'h00, "reset");
      wr(3'(r), 8'hFF);
      rd(3'(r), mask[r], "mask");
      wr(3'(r), 8'h00);
    end
    be <= 4'h0;
    wr(3'h2, 8'hFF);
    be <= 4'h1;
    rd(3'h2, 8'h00, "byteenable");
    // Single sources first, then random mixes of flags and enables
    for (int k = 0; k < 24; k++) begin
      en = (k < 8) ? 8'h01 << k : 8'($urandom);
      fl = (k < 8) ? en : 8'($urandom) | (8'h01 << k[2:0]);
      slow <= 1'($urandom);
      for (int r = 0; r < 5; r++) wr(3'(r), 8'h00);
      wr(3'h3, 8'h08);
      wr(3'h4, 8'h02);
      for (int r = 0; r < 3; r++) wr(3'(r), enb(en, r));
      fire(evv(fl), 1'b1);
      fire(evv(fl), 1'b0);
      ready_en <= 1'b1;
      take(1'b0, 12'h000);
      wr(3'h0, enb(en, 0) | {1'b0, fl[2:0], 4'h1});
      w = win(en & fl);
      take(w < 8, 12'h004 + 12'(4 * w));
      ready_en <= 1'b0;
      if (w < 8) begin
        bus(1'b0, 3'h0, 8'h00, q);
        chk("global_irq_enable", 12'(q[0]), 12'h000);
        bus(1'b0, 3'(er[w]), 8'h00, q);
        chk("flag", 12'(q[eb[w] + (er[w] == 0 ? 3 : 4)]), 12'h000);
        if (fl[4]) rd(3'h3, 8'h88, "member");
        for (int r = 0; r < 5; r++) wr(3'(r), 8'h00);
        ret();
      end
    end
    // Nest until the stack is full, then one return frees a slot
    slow <= 1'b0;
    wr(3'h0, 8'h02);
    ready_en <= 1'b1;
    for (int s = 0; s < 9; s++) begin
      fire(evv(8'h01), 1'b1);
      wr(3'h0, 8'h13);
      take(s < 8, 12'h004);
    end
    ret();
    take(1'b1, 12'h004);
    ready_en <= 1'b0;
    repeat (8) ret();
    conclude();
  end
endmodule : mcu_interrupt_controller_test
